//--- design/pin_irq_pkg.sv
// Purpose: constants and types for the pin change interrupt flag block
// Assumes: AHB-Lite register access, 32-bit words, one word per register
// Notes: printed offsets are not all multiples of four, so they are indices
package pin_irq_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL   = 8'hE9;
    localparam logic [7:0] IDX_NEG_EN    = 8'hEA;
    localparam logic [7:0] IDX_POS_EN    = 8'hEB;
    localparam logic [7:0] IDX_FLAGS     = 8'hEC;
    localparam logic [7:0] IDX_PRIO_LOW  = 8'hEF;
    localparam logic [7:0] IDX_PRIO_HIGH = 8'hF7;
    localparam logic [7:0] IDX_PIN_STATE = 8'hF8;
    localparam logic [7:0] IDX_PRIO_LVL  = 8'hF9;
    // reset values
    localparam logic [7:0] RST_REG = 8'h00;
    // field positions
    localparam int POS_PORT_SEL = 0;
    localparam int POS_TYPE_0   = 2;
    localparam int POS_TYPE_45  = 6;
    localparam int POS_TYPE_67  = 7;
    localparam int POS_PIN_PRIO = 1;
    // ahb htrans codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

    // pending address phase captured for the data phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] index;
    } bus_req_t;
endpackage : pin_irq_pkg

//--- design/pin_irq_flags.sv
// Purpose: eight-channel pin change interrupt flags with AHB-Lite registers
// Assumes: single clock hclk at 40 MHz, async active-low hresetn
// Notes: pins pass a two-flop synchroniser before any detection logic
module pin_irq_flags
    import pin_irq_pkg::*;
#(
    parameter int NUM_PORTS = 4
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // port pins, port p on bits 8p+7..8p
    input  wire logic [31:0] port_pins,
    // flags and priority towards the interrupt controller
    output logic      [7:0]  pin_irq_flag_bits,
    output logic      [1:0]  pin_irq_level
);
    // elaboration check: the channel routing serves exactly four ports
    if (NUM_PORTS != 4) begin : g_bad_ports
        $error("pin_irq_flags supports exactly four ports");
    end

    // decode of index from a byte address, used at the address phase
    function automatic logic [7:0] addr_index(input logic [31:0] a);
        return a[9:2];
    endfunction : addr_index

    logic [7:0]  pin_irq_control_q, pin_irq_control_d;
    logic [7:0]  neg_en_q, neg_en_d, pos_en_q, pos_en_d;
    logic [7:0]  flags_q, flags_d;
    logic [7:0]  prio_low_q, prio_low_d, prio_high_q, prio_high_d;
    logic [31:0] sync1_q, sync2_q;
    logic [7:0]  chan_prev_q, chan_prev_d;
    logic [31:0] hrdata_q, hrdata_d;
    bus_req_t    req_q, req_d;
    logic [7:0]  chan_now, edge_mode, rise, fall, hw_set, sw_clr;
    logic [1:0]  port_sel;
    logic        wr_now;
    logic [7:0]  edge_set;
    logic        rd_accept;

    // two-flop synchroniser; sync1_q feeds only sync2_q
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 32'h0000_0000;
            sync2_q <= 32'h0000_0000;
        end else begin
            sync1_q <= port_pins;
            sync2_q <= sync1_q;
        end
    end

    // port selection and per-channel trigger type
    always_comb begin
        port_sel = pin_irq_control_q[POS_PORT_SEL +: 2];
        chan_now = sync2_q[{port_sel, 3'h0} +: 8];
        edge_mode[3:0] = pin_irq_control_q[POS_TYPE_0 +: 4];
        edge_mode[5:4] = {2{pin_irq_control_q[POS_TYPE_45]}};
        edge_mode[7:6] = {2{pin_irq_control_q[POS_TYPE_67]}};
        rise = chan_now & ~chan_prev_q;
        fall = ~chan_now & chan_prev_q;
        hw_set = (rise & pos_en_q) | (fall & neg_en_q);
    end

    // data-phase write to the flag register
    assign wr_now = req_q.valid && req_q.write;
    assign sw_clr = (wr_now && req_q.index == IDX_FLAGS) ? ~hwdata[7:0] : 8'h00;

    // flag next-state, one bit per channel
    generate
        for (genvar n = 0; n < 8; n++) begin : g_chan
            always_comb begin
                if (!edge_mode[n]) begin
                    // level mode follows inverted pin, write has no effect
                    flags_d[n] = ~chan_now[n];
                end else if (hw_set[n]) begin
                    flags_d[n] = 1'b1;
                end else if (sw_clr[n]) begin
                    flags_d[n] = 1'b0;
                end else begin
                    flags_d[n] = flags_q[n];
                end
            end
        end
    endgenerate

    // bus and register next-state
    always_comb begin
        req_d             = req_q;
        pin_irq_control_d = pin_irq_control_q;
        neg_en_d          = neg_en_q;
        pos_en_d          = pos_en_q;
        prio_low_d        = prio_low_q;
        prio_high_d       = prio_high_q;
        chan_prev_d       = chan_now;
        hrdata_d          = hrdata_q;
        if (wr_now) begin
            case (req_q.index)
                IDX_CONTROL:   pin_irq_control_d = hwdata[7:0];
                IDX_NEG_EN:    neg_en_d          = hwdata[7:0];
                IDX_POS_EN:    pos_en_d          = hwdata[7:0];
                IDX_PRIO_LOW:  prio_low_d        = hwdata[7:0];
                IDX_PRIO_HIGH: prio_high_d       = hwdata[7:0];
                default:       ;
            endcase
        end
        if (hready) begin
            req_d.valid = hsel && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
            req_d.write = hwrite;
            req_d.index = addr_index(haddr);
            hrdata_d    = 32'h0000_0000;
            if (hsel && htrans[1] && !hwrite) begin
                case (addr_index(haddr))
                    IDX_CONTROL:   hrdata_d[7:0] = pin_irq_control_q;
                    IDX_NEG_EN:    hrdata_d[7:0] = neg_en_q;
                    IDX_POS_EN:    hrdata_d[7:0] = pos_en_q;
                    IDX_FLAGS:     hrdata_d[7:0] = flags_q;
                    IDX_PRIO_LOW:  hrdata_d[7:0] = prio_low_q;
                    IDX_PRIO_HIGH: hrdata_d[7:0] = prio_high_q;
                    IDX_PIN_STATE: hrdata_d[7:0] = chan_now;
                    IDX_PRIO_LVL:  hrdata_d[1:0] = pin_irq_level;
                    default:       hrdata_d      = 32'h0000_0000;
                endcase
            end
        end
    end

    // register all state except the synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q             <= '0;
            pin_irq_control_q <= RST_REG;
            neg_en_q          <= RST_REG;
            pos_en_q          <= RST_REG;
            flags_q           <= RST_REG;
            prio_low_q        <= RST_REG;
            prio_high_q       <= RST_REG;
            chan_prev_q       <= 8'h00;
            hrdata_q          <= 32'h0000_0000;
        end else begin
            req_q             <= req_d;
            pin_irq_control_q <= pin_irq_control_d;
            neg_en_q          <= neg_en_d;
            pos_en_q          <= pos_en_d;
            flags_q           <= flags_d;
            prio_low_q        <= prio_low_d;
            prio_high_q       <= prio_high_d;
            chan_prev_q       <= chan_prev_d;
            hrdata_q          <= hrdata_d;
        end
    end

    // outputs; slave is zero wait state, always okay
    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign hrdata            = hrdata_q;
    assign pin_irq_flag_bits = flags_q;
    assign pin_irq_level     = {prio_high_q[POS_PIN_PRIO],
                                prio_low_q[POS_PIN_PRIO]};

    // helper terms for the checks below
    assign edge_set  = edge_mode & hw_set;
    assign rd_accept = hready && hsel && htrans[1] && !hwrite;

    // edge flag sets one cycle after an enabled rising edge
    AST_EDGE_RISE_SETS: assert property (@(posedge hclk) disable iff (!hresetn)
        edge_mode[0] && rise[0] && pos_en_q[0] |=> flags_q[0])
        else $error("enabled rising edge did not set flag 0");
    // falling edge with negative enable
    AST_EDGE_FALL_SETS: assert property (@(posedge hclk) disable iff (!hresetn)
        edge_mode[3] && fall[3] && neg_en_q[3] |=> flags_q[3])
        else $error("enabled falling edge did not set flag 3");
    // rising edge with positive enable clear leaves flag alone
    AST_EDGE_DISABLED: assert property (@(posedge hclk) disable iff (!hresetn)
        edge_mode[4] && rise[4] && !pos_en_q[4] && !sw_clr[4] && !flags_q[4]
        |=> !flags_q[4])
        else $error("flag 4 set by a disabled rising edge");
    // falling edge with negative enable clear leaves flag alone
    AST_FALL_DISABLED: assert property (@(posedge hclk) disable iff (!hresetn)
        edge_mode[1] && fall[1] && !neg_en_q[1] && !sw_clr[1] && !flags_q[1]
        |=> !flags_q[1])
        else $error("flag 1 set by a disabled falling edge");
    // set flag holds without software clear
    AST_EDGE_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        edge_mode[2] && flags_q[2] && !sw_clr[2] |=> flags_q[2])
        else $error("edge flag 2 cleared by hardware");
    // software clear works and set wins over it
    AST_CLEAR_SET_WINS: assert property (@(posedge hclk) disable iff (!hresetn)
        edge_mode[4] && sw_clr[4] |=> flags_q[4] == $past(hw_set[4]))
        else $error("flag 4 clear or set priority wrong");
    // level mode follows inverse of the pin, armed only once reset has gone
    AST_LEVEL_FOLLOWS: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && !edge_mode[5] |=> flags_q[5] == !$past(chan_now[5]))
        else $error("level flag 5 not inverse of pin");
    // level mode ignores writes
    AST_LEVEL_RO: assert property (@(posedge hclk) disable iff (!hresetn)
        !edge_mode[6] && sw_clr[6] && !chan_now[6] |=> flags_q[6])
        else $error("write changed level flag 6");
    // priority level low bit follows a write to the low priority register
    AST_PRIO_COMBINE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_now && req_q.index == IDX_PRIO_LOW |=> pin_irq_level[0] == $past(hwdata[1]))
        else $error("pin priority low bit not applied");
    // shared type bits for channels 4 and 5 and for channels 6 and 7
    AST_SHARED_TYPE: assert property (@(posedge hclk) disable iff (!hresetn)
        edge_mode[6] == edge_mode[7] && edge_mode[4] == edge_mode[5])
        else $error("shared type bits disagree");

    // whole-register checks on the edge flags
    // every edge channel with an enabled edge is set next cycle
    AST_EDGE_SET_ALL: assert property (@(posedge hclk) disable iff (!hresetn)
        edge_set != 8'h00 |=> (flags_q & $past(edge_set)) == $past(edge_set))
        else $error("enabled edge did not set its flag");
    // a set edge flag is never dropped by hardware
    AST_EDGE_NO_SELF_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        (flags_q & edge_mode & ~sw_clr) != 8'h00
        |=> (flags_q & $past(flags_q) & $past(edge_mode) & ~$past(sw_clr))
            == ($past(flags_q) & $past(edge_mode) & ~$past(sw_clr)))
        else $error("edge flag dropped without a software clear");
    // a clear edge flag never rises without an enabled edge
    AST_EDGE_NO_SPURIOUS: assert property (@(posedge hclk) disable iff (!hresetn)
        (~flags_q & edge_mode & ~hw_set) != 8'h00
        |=> (flags_q & ~$past(flags_q) & $past(edge_mode) & ~$past(hw_set)) == 8'h00)
        else $error("edge flag set without an enabled edge");
    // a software clear drops an edge flag when no edge comes with it
    AST_EDGE_CLEAR_ALL: assert property (@(posedge hclk) disable iff (!hresetn)
        (edge_mode & sw_clr & ~hw_set) != 8'h00
        |=> (flags_q & $past(edge_mode) & $past(sw_clr) & ~$past(hw_set)) == 8'h00)
        else $error("software clear of an edge flag lost");

    // level channels, all bits at once
    // level flags show the inverted pin one cycle later and ignore writes
    AST_LEVEL_ALL: assert property (@(posedge hclk) disable iff (!hresetn)
        hresetn && edge_mode != 8'hFF
        |=> ((flags_q ^ ~$past(chan_now)) & ~$past(edge_mode)) == 8'h00)
        else $error("level flag not the inverse of its pin");

    // port routing; the selected port's synchronised byte feeds the channels
    // port 0 sits on pins 7..0
    AST_PORT_0: assert property (@(posedge hclk) disable iff (!hresetn)
        port_sel == 2'h0 |-> chan_now == sync2_q[7:0])
        else $error("port 0 not routed to the channels");
    // port 1 sits on pins 15..8
    AST_PORT_1: assert property (@(posedge hclk) disable iff (!hresetn)
        port_sel == 2'h1 |-> chan_now == sync2_q[15:8])
        else $error("port 1 not routed to the channels");
    // port 2 sits on pins 23..16
    AST_PORT_2: assert property (@(posedge hclk) disable iff (!hresetn)
        port_sel == 2'h2 |-> chan_now == sync2_q[23:16])
        else $error("port 2 not routed to the channels");
    // port 3 sits on pins 31..24
    AST_PORT_3: assert property (@(posedge hclk) disable iff (!hresetn)
        port_sel == 2'h3 |-> chan_now == sync2_q[31:24])
        else $error("port 3 not routed to the channels");

    // register writes land at the end of the data phase
    // control word: port select and trigger types
    AST_CONTROL_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_now && req_q.index == IDX_CONTROL |=> pin_irq_control_q == $past(hwdata[7:0]))
        else $error("control write not applied");
    // negative polarity enables
    AST_NEG_EN_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_now && req_q.index == IDX_NEG_EN |=> neg_en_q == $past(hwdata[7:0]))
        else $error("negative enable write not applied");
    // positive polarity enables
    AST_POS_EN_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_now && req_q.index == IDX_POS_EN |=> pos_en_q == $past(hwdata[7:0]))
        else $error("positive enable write not applied");
    // high priority bit reaches the level output
    AST_PRIO_HIGH_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_now && req_q.index == IDX_PRIO_HIGH |=> pin_irq_level[1] == $past(hwdata[1]))
        else $error("pin priority high bit not applied");

    // reads return the register as it stood at the address phase
    // flag register
    AST_FLAG_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_accept && addr_index(haddr) == IDX_FLAGS
        |=> hrdata == {24'h00_0000, $past(flags_q)})
        else $error("flag read data wrong");
    // control register
    AST_CONTROL_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_accept && addr_index(haddr) == IDX_CONTROL
        |=> hrdata == {24'h00_0000, $past(pin_irq_control_q)})
        else $error("control read data wrong");
    // selected port pin state
    AST_PIN_STATE_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_accept && addr_index(haddr) == IDX_PIN_STATE
        |=> hrdata == {24'h00_0000, $past(chan_now)})
        else $error("pin state read data wrong");
    // combined priority level
    AST_LEVEL_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_accept && addr_index(haddr) == IDX_PRIO_LVL
        |=> hrdata == {30'h0000_0000, $past(pin_irq_level)})
        else $error("priority level read data wrong");
    // unmapped index 0 reads as zero
    AST_UNMAPPED_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_accept && addr_index(haddr) == 8'h00
        |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule : pin_irq_flags

//--- verif/pin_source.sv
// Purpose: outside circuitry that drives the four port pin groups
// Assumes: pins change one clock after the bench asks for new levels
// Notes: pins are always driven, so no released or floating state exists
module pin_source (
    // clock
    input  wire logic        hclk,
    // levels asked for by the bench
    input  wire logic [31:0] pin_set,
    // levels seen at the port pins
    output logic      [31:0] port_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // outside driver follows the request one clock later
    always_ff @(posedge hclk) begin
        port_pins <= pin_set;
    end
endmodule : pin_source

//--- verif/tb_top.sv
// Purpose: self-checking bench for the pin change interrupt flags
// Assumes: zero-wait slave, read data registered at the address phase
// Notes: reads queue their expected value, a monitor compares it
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pin_irq_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] pin_set = 32'hFFFFFFFF;
    logic [31:0] hrdata, port_pins, v;
    logic        hreadyout, hresp;
    logic [7:0]  flags;
    logic [1:0]  level;
    logic        rd_phase = 1'b0;
    logic [7:0]  exp_q[$];
    logic [31:0] rng = 32'd43149;
    int          fails = 0;
    int          cmp_count = 0;
    // clock of 25 ns
    always #12.5 hclk = ~hclk;
    pin_source i_pin_source (.hclk(hclk), .pin_set(pin_set), .port_pins(port_pins));
    pin_irq_flags i_pin_irq_flags (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .port_pins(port_pins), .pin_irq_flag_bits(flags), .pin_irq_level(level));
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check
    task automatic close_out();
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    // one single word transfer, address phase then data phase
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans   <= 2'h0;
        hwdata   <= {24'h0, d};
        rd_phase <= !w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd_phase <= 1'b0;
    endtask : xfer
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        exp_q.push_back(e);
        xfer(1'b0, idx, 8'h00);
    endtask : rd
    task automatic pins(input logic [31:0] p);
        @(posedge hclk);
        pin_set <= p;
        repeat (6) @(posedge hclk);
    endtask : pins
    // monitor takes the oldest note when read data stands
    always @(posedge hclk) begin
        if (rd_phase && hreadyout === 1'b1) begin
            check("hrdata", {24'h0, exp_q.pop_front()}, hrdata);
            check("hresp", 32'h0, {31'h0, hresp});
        end
    end
    // main sequence
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rd(IDX_CONTROL, 8'h00);
        rd(IDX_NEG_EN, 8'h00);
        rd(IDX_POS_EN, 8'h00);
        rd(IDX_PRIO_LOW, 8'h00);
        rd(IDX_FLAGS, 8'h00);
        rd(8'h00, 8'h00);
        for (int p = 0; p < 4; p++) begin
            v = xs();
            pins(v);
            xfer(1'b1, IDX_CONTROL, 8'(p));
            repeat (3) @(posedge hclk);
            rd(IDX_FLAGS, ~v[8*p +: 8]);
            xfer(1'b1, IDX_FLAGS, 8'h00);
            rd(IDX_FLAGS, ~v[8*p +: 8]);
            @(negedge hclk);
            check("flags", {24'h0, ~v[8*p +: 8]}, {24'h0, flags});
        end
        // channels 0..5 edge, 6/7 level, port 0
        pins(32'hFFFFFFFF);
        xfer(1'b1, IDX_POS_EN, 8'h0F);
        xfer(1'b1, IDX_NEG_EN, 8'h30);
        xfer(1'b1, IDX_CONTROL, 8'h7C);
        rd(IDX_CONTROL, 8'h7C);
        rd(IDX_NEG_EN, 8'h30);
        rd(IDX_POS_EN, 8'h0F);
        rd(IDX_PIN_STATE, 8'hFF);
        repeat (3) @(posedge hclk);
        xfer(1'b1, IDX_FLAGS, 8'h00);
        rd(IDX_FLAGS, 8'h00);
        pins(32'h0);
        rd(IDX_FLAGS, 8'hF0);
        pins(32'hFFFFFFFF);
        rd(IDX_FLAGS, 8'h3F);
        repeat (20) @(posedge hclk);
        rd(IDX_FLAGS, 8'h3F);
        xfer(1'b1, IDX_FLAGS, 8'h2A);
        rd(IDX_FLAGS, 8'h2A);
        pins(32'h0);
        xfer(1'b1, IDX_FLAGS, 8'h0F);
        rd(IDX_FLAGS, 8'hCA);
        pins(32'hFFFFFFFF);
        rd(IDX_FLAGS, 8'h0F);
        xfer(1'b1, IDX_PRIO_LOW, 8'h02);
        rd(IDX_PRIO_LOW, 8'h02);
        @(negedge hclk);
        check("level", 32'h1, {30'h0, level});
        xfer(1'b1, IDX_PRIO_HIGH, 8'h02);
        repeat (2) @(negedge hclk);
        check("level", 32'h3, {30'h0, level});
        rd(IDX_PRIO_LVL, 8'h03);
        repeat (2) @(posedge hclk);
        close_out();
    end
    // watchdog against a hung bus
    initial begin
        #500000;
        fails++;
        close_out();
    end
endmodule : tb_top
